// *** rtl/light_screen_status.sv ***
// reset sequencing and lamp/display logic for a safety light screen receiver and emitter
// assumes all pin inputs are synchronous to MCLK; registers reached over APB
//
// Contract
// - reset accepted only for closures 1/4 to 2 s
// - trip mode: manual reset only after lockout
// - latch mode: reset at power-up, latch, lockout
// - lockout exits only by reset after fault clears
// - emitter lockout cleared only by power cycle
// - emitter lamp: flash red, green, blink green/red
// - emitter digit: error, dash, or scan code
// - eight two-colour zone lamps
// - zone green when clear, red when blocked
// - first beam blocked: zone one red, others dark
// - status green outputs on, red off, blink lockout
// - reset lamp shows run or pending reset
// - run clear: outputs on, green, blink if reduced
// - blocked: outputs off, red, show blocked count
// - display shows mode, or error in lockout
// - trip mode: outputs return once beams clear
// - open test contact acts as blocked beams
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module light_screen_status
  import lsr_pkg::*;
#(
  parameter int RESET_MIN_CYC_P = RESET_MIN_CYC,
  parameter int RESET_MAX_CYC_P = RESET_MAX_CYC,
  parameter int BLINK_HALF_CYC_P = BLINK_HALF_CYC
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RESET_SW, // high while the reset switch is closed
  input wire logic BEAM1_BLOCKED, // first (sync) beam blocked
  input wire logic [7:0] ZONE_BLOCKED, // one bit per zone, any beam blocked
  input wire logic [7:0] BLOCKED_COUNT, // number of blocked beams
  input wire logic RX_FAULT, // receiver internal or external fault
  input wire logic [7:0] RX_FAULT_CODE,
  input wire logic RESET_NOISE, // noise seen on the reset input
  input wire logic FEEDBACK_NOISE, // noise seen on the contact_feedback_monitor input
  input wire logic TEST_OPEN, // emitter remote test contact open
  input wire logic EMIT_FAULT,
  input wire logic [3:0] EMIT_FAULT_CODE,
  output logic [1:0] SAFETY_OUTPUT_PAIR,
  output logic STATUS_RED,
  output logic STATUS_GREEN,
  output logic RESET_LAMP,
  output logic [7:0] ZONE_RED,
  output logic [7:0] ZONE_GREEN,
  output logic [7:0] DISP_LEFT,
  output logic [7:0] DISP_MID,
  output logic [7:0] DISP_RIGHT,
  output logic EMIT_RED,
  output logic EMIT_GREEN,
  output logic [7:0] EMIT_DISP
);

  localparam logic [CNT_W-1:0] BLINK_LAST = CNT_W'(BLINK_HALF_CYC_P - 1);

  logic [CTRL_W-1:0] ctrl; // latch mode, reduced resolution, scan code
  logic latch_mode;
  logic reduced_res;
  logic scan_sel;
  rx_state_e state; // receiver state
  rx_state_e next_state;
  logic reset_needed; // latch mode: reset owed before outputs may turn on
  logic armed; // lockout: switch seen open since entry
  logic [7:0] lock_code; // receiver error code caught at lockout entry
  logic em_lock; // emitter lockout, left only by power cycle
  logic [3:0] em_code; // emitter error code
  logic reset_req; // qualified reset pulse
  logic [CNT_W-1:0] blink_cnt; // common blink timer
  logic blink_phase; // high in the lit half of a flash
  logic blink_tick; // one-cycle pulse at each half-period edge
  logic [2:0] pu_halves; // half periods spent in power-up
  logic [2:0] scan_show; // half periods left showing the scan code
  logic scan_prev; // scan code one cycle ago
  logic beam1_blk;
  logic [7:0] zones_blk;
  logic all_clear;
  logic out_on;
  logic apb_hit;
  logic [31:0] rd_mux;
  logic rd_ok;
  logic next_st_red, next_st_green, next_rst_lamp, next_em_red, next_em_green;
  logic [7:0] next_zr, next_zg, next_dl, next_dm, next_dr, next_ed;

  assign latch_mode = ctrl[CTRL_LATCH_BIT];
  assign reduced_res = ctrl[CTRL_RRES_BIT];
  assign scan_sel = ctrl[CTRL_SCAN_BIT];

  // an open test contact stops emission, which the receiver sees as every beam blocked
  assign beam1_blk = BEAM1_BLOCKED | TEST_OPEN;
  assign zones_blk = TEST_OPEN ? 8'hff : ZONE_BLOCKED;
  assign all_clear = !beam1_blk && (zones_blk == 8'h00);

  // safety outputs only in run with every beam clear and no reset owed
  assign out_on = (state == RX_RUN) && all_clear && !(latch_mode && reset_needed);

  // decimal value of a blocked-beam count as three display digits
  function automatic logic [23:0] dec3(input logic [7:0] v);
    logic [7:0] h, t, u;
    h = v / 8'd100;
    t = (v / 8'd10) % 8'd10;
    u = v % 8'd10;
    return {h, t, u};
  endfunction : dec3

  reset_qualifier #(
    .MIN_CYC(RESET_MIN_CYC_P),
    .MAX_CYC(RESET_MAX_CYC_P)
  ) u_qual (
    .clk(MCLK),
    .rst(RST),
    .closed(RESET_SW),
    .accept(reset_req)
  );

  // free-running blink timer shared by every flashing indication
  always_ff @(posedge MCLK) begin
    if (RST) begin
      blink_cnt <= '0;
      blink_phase <= 1'b1;
      blink_tick <= 1'b0;
    end else begin
      blink_tick <= (blink_cnt == BLINK_LAST);
      if (blink_cnt == BLINK_LAST) begin
        blink_cnt <= '0;
        blink_phase <= !blink_phase;
      end else begin
        blink_cnt <= blink_cnt + 1'b1;
      end
    end
  end

  // power-up length and scan code display window, counted in blink halves
  always_ff @(posedge MCLK) begin
    if (RST) begin
      pu_halves <= 3'h0;
      scan_show <= 3'h0;
      scan_prev <= 1'b0;
    end else begin
      scan_prev <= scan_sel;
      if (blink_tick && state == RX_POWERUP && pu_halves != POWERUP_HALVES) begin
        pu_halves <= pu_halves + 3'h1;
      end
      if (scan_sel != scan_prev) begin
        scan_show <= SCAN_SHOW_HALVES;
      end else if (blink_tick && scan_show != 3'h0) begin
        scan_show <= scan_show - 3'h1;
      end
    end
  end

  // receiver state sequence
  always_comb begin
    next_state = state;
    case (state)
      RX_POWERUP: begin
        if (RX_FAULT) next_state = RX_LOCKOUT;
        else if (pu_halves == POWERUP_HALVES) next_state = RX_ALIGN;
      end
      RX_ALIGN: begin
        if (RX_FAULT) next_state = RX_LOCKOUT;
        else if (all_clear) next_state = RX_RUN;
      end
      RX_RUN: begin
        if (RX_FAULT) next_state = RX_LOCKOUT;
      end
      RX_LOCKOUT: begin
        // only a properly cycled reset after the fault is gone leaves lockout
        if (!RX_FAULT && armed && reset_req) next_state = RX_ALIGN;
      end
      default: next_state = RX_LOCKOUT;
    endcase
  end

  // state register and lockout bookkeeping
  always_ff @(posedge MCLK) begin
    if (RST) begin
      state <= RX_POWERUP;
      armed <= 1'b0;
      lock_code <= 8'h00;
    end else begin
      state <= next_state;
      if (state != RX_LOCKOUT && next_state == RX_LOCKOUT) begin
        lock_code <= RX_FAULT_CODE;
        armed <= !RESET_SW;
      end else if (state == RX_LOCKOUT && !RESET_SW) begin
        armed <= 1'b1;
      end
    end
  end

  // owed reset in latch mode; a latch event in the same cycle as a reset wins
  always_ff @(posedge MCLK) begin
    if (RST) begin
      reset_needed <= 1'b1;
    end else begin
      if (reset_req && all_clear && state == RX_RUN) reset_needed <= 1'b0;
      if (state == RX_LOCKOUT && next_state == RX_ALIGN) reset_needed <= 1'b0;
      if (state == RX_POWERUP || next_state == RX_LOCKOUT) reset_needed <= 1'b1;
      if (state == RX_RUN && !all_clear && SAFETY_OUTPUT_PAIR != 2'b00) reset_needed <= 1'b1;
    end
  end

  // emitter lockout holds until power is removed and reapplied
  always_ff @(posedge MCLK) begin
    if (RST) begin
      em_lock <= 1'b0;
      em_code <= 4'h0;
    end else if (EMIT_FAULT && !em_lock) begin
      em_lock <= 1'b1;
      em_code <= EMIT_FAULT_CODE;
    end
  end

  // receiver lamps and display
  always_comb begin
    logic [23:0] cnt_digits;
    logic [7:0] scan_digit;
    cnt_digits = dec3(BLOCKED_COUNT);
    scan_digit = scan_sel ? SYM_TWO : SYM_ONE;
    next_st_red = 1'b0;
    next_st_green = 1'b0;
    next_rst_lamp = 1'b0;
    next_zr = 8'h00;
    next_zg = 8'h00;
    next_dl = SYM_BLANK;
    next_dm = latch_mode ? SYM_LATCH : SYM_DASH;
    next_dr = SYM_BLANK;
    case (state)
      RX_POWERUP: begin
        // one red flash on status and zones, scan code flashed three times
        next_st_red = blink_phase && (pu_halves == 3'h0);
        next_zr = (blink_phase && pu_halves == 3'h0) ? 8'hff : 8'h00;
        next_dm = blink_phase ? scan_digit : SYM_BLANK;
      end
      RX_LOCKOUT: begin
        next_st_red = blink_phase;
        next_dl = SYM_ERR;
        next_dm = {4'h0, lock_code[7:4]};
        next_dr = {4'h0, lock_code[3:0]};
      end
      default: begin
        if (beam1_blk) begin
          next_zr = 8'h01;
        end else begin
          next_zr = zones_blk;
          next_zg = ~zones_blk;
        end
        if (out_on) begin
          next_st_green = reduced_res ? blink_phase : 1'b1;
        end else if (!(state == RX_ALIGN && beam1_blk)) begin
          next_st_red = 1'b1;
        end
        if (!all_clear) begin
          next_dl = cnt_digits[23:16];
          next_dm = cnt_digits[15:8];
          next_dr = cnt_digits[7:0];
        end else if (scan_show != 3'h0) begin
          next_dm = scan_digit;
        end
        if (state == RX_ALIGN && beam1_blk) begin
          next_rst_lamp = 1'b0;
        end else if (latch_mode && reset_needed && all_clear) begin
          next_rst_lamp = blink_phase;
        end else begin
          next_rst_lamp = 1'b1;
        end
      end
    endcase
    // noise flashes one end digit, leaving the rest as it was
    if (RESET_NOISE && !blink_phase) next_dl = SYM_BLANK;
    if (FEEDBACK_NOISE && !blink_phase) next_dr = SYM_BLANK;
  end

  // emitter lamp and digit
  always_comb begin
    next_em_red = 1'b0;
    next_em_green = 1'b0;
    next_ed = SYM_DASH;
    if (em_lock) begin
      next_em_red = blink_phase;
      next_ed = {4'h0, em_code};
    end else if (state == RX_POWERUP) begin
      next_em_red = blink_phase && (pu_halves == 3'h0);
      next_ed = scan_sel ? SYM_TWO : SYM_ONE;
    end else begin
      next_em_green = TEST_OPEN ? blink_phase : 1'b1;
      if (scan_show != 3'h0) next_ed = scan_sel ? SYM_TWO : SYM_ONE;
    end
  end

  // registered indication outputs
  always_ff @(posedge MCLK) begin
    if (RST) begin
      SAFETY_OUTPUT_PAIR <= 2'b00;
      STATUS_RED <= 1'b0;
      STATUS_GREEN <= 1'b0;
      RESET_LAMP <= 1'b0;
      ZONE_RED <= 8'h00;
      ZONE_GREEN <= 8'h00;
      DISP_LEFT <= SYM_BLANK;
      DISP_MID <= SYM_BLANK;
      DISP_RIGHT <= SYM_BLANK;
      EMIT_RED <= 1'b0;
      EMIT_GREEN <= 1'b0;
      EMIT_DISP <= SYM_BLANK;
    end else begin
      SAFETY_OUTPUT_PAIR <= out_on ? 2'b11 : 2'b00;
      STATUS_RED <= next_st_red;
      STATUS_GREEN <= next_st_green;
      RESET_LAMP <= next_rst_lamp;
      ZONE_RED <= next_zr;
      ZONE_GREEN <= next_zg;
      DISP_LEFT <= next_dl;
      DISP_MID <= next_dm;
      DISP_RIGHT <= next_dr;
      EMIT_RED <= next_em_red;
      EMIT_GREEN <= next_em_green;
      EMIT_DISP <= next_ed;
    end
  end

  // APB slave: one wait cycle, then registered answer
  assign apb_hit = PSEL && PENABLE;

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    case (PADDR)
      ADDR_CTRL: rd_mux[CTRL_W-1:0] = ctrl;
      ADDR_STATUS: begin
        rd_mux[STAT_OUT_BIT] = SAFETY_OUTPUT_PAIR[0];
        rd_mux[STAT_PEND_BIT] = latch_mode && reset_needed;
        rd_mux[STAT_LOCK_BIT] = (state == RX_LOCKOUT);
        rd_mux[STAT_EMLOCK_BIT] = em_lock;
        rd_mux[STAT_STATE_LSB +: 2] = state;
      end
      ADDR_LOCK_CODE: rd_mux[7:0] = lock_code;
      default: rd_ok = 1'b0;
    endcase
    if (PWRITE && PADDR != ADDR_CTRL) rd_ok = 1'b0;
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= apb_hit && !PREADY;
      if (apb_hit && !PREADY) begin
        PRDATA <= (PWRITE || !rd_ok) ? 32'h0000_0000 : rd_mux;
        PSLVERR <= !rd_ok;
      end else begin
        PSLVERR <= 1'b0;
      end
    end
  end

  // control register: written at the edge that completes the access
  always_ff @(posedge MCLK) begin
    if (RST) begin
      ctrl <= CTRL_RESET;
    end else if (apb_hit && PREADY && PWRITE && PADDR == ADDR_CTRL) begin
      ctrl <= PWDATA[CTRL_W-1:0];
    end
  end

  chk_outputs_cause: assert property (@(posedge MCLK) disable iff (RST)
    (SAFETY_OUTPUT_PAIR != 2'b00) |-> ($past(state) == RX_RUN && $past(all_clear)))
    else $error("safety outputs on without run and clear beams");

  chk_latch_hold: assert property (@(posedge MCLK) disable iff (RST)
    (latch_mode && reset_needed && state == RX_RUN) |=> SAFETY_OUTPUT_PAIR == 2'b00)
    else $error("latch mode outputs on while reset owed");

  chk_trip_auto: assert property (@(posedge MCLK) disable iff (RST)
    (!latch_mode && state == RX_RUN && all_clear) |=> SAFETY_OUTPUT_PAIR == 2'b11)
    else $error("trip mode outputs did not return when clear");

  chk_lockout_exit: assert property (@(posedge MCLK) disable iff (RST)
    ($past(state) == RX_LOCKOUT && state != RX_LOCKOUT) |-> ($past(reset_req) && !$past(RX_FAULT)))
    else $error("lockout left without a qualified reset");

  chk_emit_sticky: assert property (@(posedge MCLK) disable iff (RST)
    em_lock |=> em_lock)
    else $error("emitter lockout cleared without power cycle");

  chk_beam1_zones: assert property (@(posedge MCLK) disable iff (RST)
    (beam1_blk && (state == RX_ALIGN || state == RX_RUN)) |=> (ZONE_RED == 8'h01 && ZONE_GREEN == 8'h00))
    else $error("zones not dark with first beam blocked");

  chk_lockout_dark: assert property (@(posedge MCLK) disable iff (RST)
    (state == RX_LOCKOUT) |=> (ZONE_RED == 8'h00 && ZONE_GREEN == 8'h00 && !STATUS_GREEN && DISP_LEFT != SYM_DASH))
    else $error("lockout indications wrong");

  chk_powerup_off: assert property (@(posedge MCLK) disable iff (RST)
    (state == RX_POWERUP) |=> (SAFETY_OUTPUT_PAIR == 2'b00 && !RESET_LAMP))
    else $error("power-up drove outputs or reset lamp");

endmodule : light_screen_status
`default_nettype wire

// *** rtl/lsr_pkg.sv ***
// constants, register map, display symbols and state type for the light screen status block
// assumes a single 100 MHz system clock; all counts are derived from it here
package lsr_pkg;

  // clock rate in kHz, so that milliseconds times this gives cycles
  localparam int CLK_KHZ = 100_000;

  // reset switch closure window, in milliseconds
  localparam int RESET_MIN_MS = 250;
  localparam int RESET_MAX_MS = 2000;
  // least closure rounds up, longest rounds down; both are exact at this rate
  localparam int RESET_MIN_CYC = RESET_MIN_MS * CLK_KHZ;
  localparam int RESET_MAX_CYC = RESET_MAX_MS * CLK_KHZ;

  // half period of the common blink timer, in milliseconds
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;

  // width of the long counters (2 s at 100 MHz fits in 28 bits)
  localparam int CNT_W = 28;

  // power-up lasts three blink periods; scan code display after a change lasts two
  localparam logic [2:0] POWERUP_HALVES = 3'h6;
  localparam logic [2:0] SCAN_SHOW_HALVES = 3'h4;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LOCK_CODE = 8'h08;

  // control register fields and reset value
  localparam int CTRL_LATCH_BIT = 0;
  localparam int CTRL_RRES_BIT = 1;
  localparam int CTRL_SCAN_BIT = 2;
  localparam int CTRL_W = 3;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // status register fields
  localparam int STAT_OUT_BIT = 0;
  localparam int STAT_PEND_BIT = 1;
  localparam int STAT_LOCK_BIT = 2;
  localparam int STAT_EMLOCK_BIT = 3;
  localparam int STAT_STATE_LSB = 4;

  // display symbol codes: 8'h00..8'h0f are hex digits
  localparam logic [7:0] SYM_DASH = 8'h10;
  localparam logic [7:0] SYM_LATCH = 8'h11;
  localparam logic [7:0] SYM_ERR = 8'h12;
  localparam logic [7:0] SYM_BLANK = 8'h1f;
  localparam logic [7:0] SYM_ONE = 8'h01;
  localparam logic [7:0] SYM_TWO = 8'h02;

  // receiver operating states
  typedef enum logic [1:0] {RX_POWERUP, RX_ALIGN, RX_RUN, RX_LOCKOUT} rx_state_e;

endpackage : lsr_pkg

// *** rtl/reset_qualifier.sv ***
// times the reset switch closure and accepts it on the release edge
// assumes the switch level is already synchronous to the clock and debounced
`timescale 1ns/1ps
`default_nettype none
module reset_qualifier
  import lsr_pkg::*;
#(
  parameter int MIN_CYC = RESET_MIN_CYC,
  parameter int MAX_CYC = RESET_MAX_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic closed,
  output logic accept
);

  // window limits at counter width; the counter saturates one past the upper limit
  localparam logic [CNT_W-1:0] MIN_C = CNT_W'(MIN_CYC);
  localparam logic [CNT_W-1:0] MAX_C = CNT_W'(MAX_CYC);
  localparam logic [CNT_W-1:0] SAT_C = CNT_W'(MAX_CYC + 1);

  logic [CNT_W-1:0] hold_cnt; // cycles the switch has been closed
  logic was_closed; // switch level one cycle ago

  // closure timer on the system clock, cleared while open
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_cnt <= '0;
      was_closed <= 1'b0;
    end else begin
      was_closed <= closed;
      if (!closed) begin
        hold_cnt <= '0;
      end else if (hold_cnt != SAT_C) begin
        hold_cnt <= hold_cnt + 1'b1;
      end
    end
  end

  // judged on release: too short and too long closures are both dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      accept <= 1'b0;
    end else begin
      accept <= was_closed && !closed && hold_cnt >= MIN_C && hold_cnt <= MAX_C;
    end
  end

  chk_accept_window: assert property (@(posedge clk) disable iff (rst)
    accept |-> ($past(hold_cnt) >= MIN_C && $past(hold_cnt) <= MAX_C))
    else $error("reset accepted outside the closure window");

  chk_long_ignored: assert property (@(posedge clk) disable iff (rst)
    (was_closed && !closed && hold_cnt > MAX_C) |=> !accept)
    else $error("overlong reset closure was accepted");

  chk_accept_release: assert property (@(posedge clk) disable iff (rst)
    accept |-> ($past(was_closed) && !$past(closed)) ##1 !accept)
    else $error("reset accept not a single pulse on release");

endmodule : reset_qualifier
`default_nettype wire

// *** sim/op_switch_model.sv ***
// operator reset switch model: closes the contact for a commanded number of cycles
// assumes go is a one-cycle request given only while the contact is open
`timescale 1ns/1ps
`default_nettype none
module op_switch_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] len,
  output logic closed
);
  logic [7:0] left = 8'h00; // closed cycles still to run
  initial closed = 1'b0;
  // hold the contact closed for len cycles, then let it spring open
  always @(posedge clk) begin
    if (go && !closed) begin
      closed <= 1'b1;
      left <= len;
    end else if (left > 8'h01) begin
      left <= left - 8'h01;
    end else begin
      closed <= 1'b0;
      left <= 8'h00;
    end
  end
endmodule : op_switch_model
`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench for the light screen status block
// assumes shortened reset window (20..100 cycles) and a 4-cycle blink half period
`timescale 1ns/1ps
`default_nettype none
module tb
  import lsr_pkg::*;
;
  typedef struct {int sel; logic [7:0] exp;} note_s;
  logic MCLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00, ZONE_BLOCKED = 8'h00, BLOCKED_COUNT = 8'h00, RX_FAULT_CODE = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd_data;
  logic PREADY, PSLVERR, rd_err, RESET_SW, BEAM1_BLOCKED = 1'b0, RX_FAULT = 1'b0, go = 1'b0;
  logic RESET_NOISE = 1'b0, FEEDBACK_NOISE = 1'b0, TEST_OPEN = 1'b0, EMIT_FAULT = 1'b0;
  logic [3:0] EMIT_FAULT_CODE = 4'h0;
  logic [1:0] SAFETY_OUTPUT_PAIR;
  logic STATUS_RED, STATUS_GREEN, RESET_LAMP, EMIT_RED, EMIT_GREEN;
  logic [7:0] ZONE_RED, ZONE_GREEN, DISP_LEFT, DISP_MID, DISP_RIGHT, EMIT_DISP, len = 8'h00, m, c;
  int n_fail = 0, n_checks = 0, k;
  note_s notes[$];
  note_s cur;
  event look;
  string what[12] = '{"pair", "status", "zone_red", "zone_green", "reset_lamp", "disp_left", "prdata", "pslverr",
    "emit_disp", "disp_mid", "emit_lamp", "disp_right"};
  // clock at 100 MHz
  always #5 MCLK = ~MCLK;
  light_screen_status #(.RESET_MIN_CYC_P(20), .RESET_MAX_CYC_P(100), .BLINK_HALF_CYC_P(4)) u_dut (
    .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RESET_SW(RESET_SW),
    .BEAM1_BLOCKED(BEAM1_BLOCKED), .ZONE_BLOCKED(ZONE_BLOCKED), .BLOCKED_COUNT(BLOCKED_COUNT),
    .RX_FAULT(RX_FAULT), .RX_FAULT_CODE(RX_FAULT_CODE), .RESET_NOISE(RESET_NOISE),
    .FEEDBACK_NOISE(FEEDBACK_NOISE), .TEST_OPEN(TEST_OPEN), .EMIT_FAULT(EMIT_FAULT),
    .EMIT_FAULT_CODE(EMIT_FAULT_CODE), .SAFETY_OUTPUT_PAIR(SAFETY_OUTPUT_PAIR),
    .STATUS_RED(STATUS_RED), .STATUS_GREEN(STATUS_GREEN), .RESET_LAMP(RESET_LAMP),
    .ZONE_RED(ZONE_RED), .ZONE_GREEN(ZONE_GREEN), .DISP_LEFT(DISP_LEFT), .DISP_MID(DISP_MID),
    .DISP_RIGHT(DISP_RIGHT), .EMIT_RED(EMIT_RED), .EMIT_GREEN(EMIT_GREEN), .EMIT_DISP(EMIT_DISP));
  op_switch_model u_sw (.clk(MCLK), .go(go), .len(len), .closed(RESET_SW));
  // picks the observed value for a note
  function automatic logic [7:0] seen(input int s);
    case (s)
      0: seen = {6'h00, SAFETY_OUTPUT_PAIR};
      1: seen = {6'h00, STATUS_RED, STATUS_GREEN};
      2: seen = ZONE_RED;
      3: seen = ZONE_GREEN;
      4: seen = {7'h00, RESET_LAMP};
      5: seen = DISP_LEFT;
      6: seen = rd_data[7:0];
      7: seen = {7'h00, rd_err};
      8: seen = EMIT_DISP;
      9: seen = DISP_MID;
      10: seen = {6'h00, EMIT_RED, EMIT_GREEN};
      default: seen = DISP_RIGHT;
    endcase
  endfunction : seen
  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic results;
    // let the watcher drain the last notes first; a note left over counts as a failure
    #1;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0 && notes.size() == 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  task automatic give_up(input string name);
    n_fail++;
    $display("MISMATCH %s expected done seen timeout", name);
    results();
  endtask : give_up
  // watcher: takes the oldest notes and compares them with the outputs
  always @(look) begin
    while (notes.size() > 0) begin
      cur = notes.pop_front();
      check(what[cur.sel], seen(cur.sel), cur.exp);
    end
  end
  task automatic note(input int s, input logic [7:0] e);
    notes.push_back('{s, e});
    -> look;
  endtask : note
  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask : cyc
  // bounded wait for the safety outputs to reach a value
  task automatic wait_pair(input logic [1:0] e, input int lim);
    wait_on(0, {6'h00, e}, lim);
  endtask : wait_pair
  // bounded wait for any observed value, then noted as a check
  task automatic wait_on(input int s, input logic [7:0] e, input int lim);
    int i;
    for (i = 0; i < lim && seen(s) !== e; i++) cyc(1);
    if (seen(s) !== e) give_up(what[s]);
    note(s, e);
  endtask : wait_on
  // one operator closure of n cycles, then a settle margin
  task automatic closure(input logic [7:0] n);
    int i;
    @(posedge MCLK);
    go <= 1'b1;
    len <= n;
    @(posedge MCLK);
    go <= 1'b0;
    #1;
    for (i = 0; i < 300 && RESET_SW !== 1'b0; i++) cyc(1);
    if (i == 300) give_up("switch");
    cyc(4);
  endtask : closure
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge MCLK);
      if (PREADY === 1'b1) break;
    end
    rd_data = PRDATA;
    rd_err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (i == 20) give_up("pready");
    #1;
  endtask : apb
  // main sequence
  initial begin
    void'($urandom(32'h1fc38648));
    repeat (12) @(posedge MCLK);
    RST <= 1'b0;
    cyc(3);
    note(0, 8'h00);
    note(4, 8'h00);
    $display("test powerup done");
    wait_pair(2'b11, 80);
    note(1, 8'h01);
    note(3, 8'hff);
    note(9, SYM_DASH);
    note(8, SYM_DASH);
    note(10, 8'h01);
    for (k = 0; k < 4; k++) begin
      m = 8'($urandom_range(255, 1));
      @(posedge MCLK);
      ZONE_BLOCKED <= m;
      c = 8'($urandom_range(40, 1));
      BLOCKED_COUNT <= c;
      cyc(4);
      note(5, 8'h00);
      note(9, c / 8'd10);
      note(11, c % 8'd10);
      note(0, 8'h00);
      note(1, 8'h02);
      note(2, m);
      note(3, ~m);
      @(posedge MCLK);
      ZONE_BLOCKED <= 8'h00;
      BLOCKED_COUNT <= 8'h00;
      wait_pair(2'b11, 20);
    end
    @(posedge MCLK);
    BEAM1_BLOCKED <= 1'b1;
    ZONE_BLOCKED <= 8'h01;
    cyc(4);
    note(2, 8'h01);
    note(3, 8'h00);
    @(posedge MCLK);
    BEAM1_BLOCKED <= 1'b0;
    ZONE_BLOCKED <= 8'h00;
    wait_pair(2'b11, 20);
    @(posedge MCLK);
    TEST_OPEN <= 1'b1;
    cyc(4);
    note(0, 8'h00);
    wait_on(10, 8'h00, 10);
    @(posedge MCLK);
    TEST_OPEN <= 1'b0;
    wait_pair(2'b11, 20);
    $display("test trip run done");
    @(posedge MCLK);
    RX_FAULT <= 1'b1;
    RX_FAULT_CODE <= 8'h5a;
    cyc(4);
    note(0, 8'h00);
    note(2, 8'h00);
    note(5, SYM_ERR);
    note(9, 8'h05);
    note(11, 8'h0a);
    note(4, 8'h00);
    @(posedge MCLK);
    RX_FAULT <= 1'b0;
    FEEDBACK_NOISE <= 1'b1;
    wait_on(11, SYM_BLANK, 10);
    note(9, 8'h05);
    note(5, SYM_ERR);
    wait_on(11, 8'h0a, 10);
    @(posedge MCLK);
    FEEDBACK_NOISE <= 1'b0;
    cyc(8);
    note(0, 8'h00);
    closure(8'd120);
    note(0, 8'h00);
    closure(8'd10);
    note(0, 8'h00);
    closure(8'd50);
    wait_pair(2'b11, 40);
    $display("test lockout done");
    apb(1'b1, ADDR_CTRL, 32'h7);
    apb(1'b0, ADDR_CTRL, 32'h0);
    note(6, 8'h07);
    note(8, SYM_TWO);
    note(9, SYM_TWO);
    apb(1'b0, 8'h0c, 32'h0);
    note(7, 8'h01);
    note(6, 8'h00);
    wait_on(1, 8'h00, 10);
    wait_on(1, 8'h01, 10);
    @(posedge MCLK);
    ZONE_BLOCKED <= 8'h80;
    cyc(4);
    note(0, 8'h00);
    @(posedge MCLK);
    ZONE_BLOCKED <= 8'h00;
    cyc(10);
    note(0, 8'h00);
    closure(8'($urandom_range(95, 25)));
    wait_pair(2'b11, 20);
    note(9, SYM_LATCH);
    $display("test latch done");
    // emitter lockout holds after the fault goes, and only a power cycle clears it
    @(posedge MCLK);
    EMIT_FAULT <= 1'b1;
    m = 8'($urandom_range(15, 0));
    EMIT_FAULT_CODE <= m[3:0];
    cyc(4);
    note(8, m);
    wait_on(10, 8'h02, 10);
    @(posedge MCLK);
    EMIT_FAULT <= 1'b0;
    cyc(8);
    note(8, m);
    @(posedge MCLK);
    RST <= 1'b1;
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    cyc(3);
    note(8, SYM_ONE);
    note(0, 8'h00);
    $display("test emitter done");
    results();
  end
endmodule : tb
`default_nettype wire
